// file: rtl/mso_modem_out.sv
// Purpose: modem signal output, one bit per period on the modem pin
// Assumes: cpu i/o strobes and serial unit on the system clock
// Notes:   serial bits pass a two-entry buffer before the write stage
module mso_modem_out (
    input  wire logic                clock,
    input  wire logic                rstn,
    input  wire mso_pkg::mso_io_req_s io_req,
    output logic [7:0]               io_rdata,
    input  wire logic                ser_valid,
    input  wire logic                ser_data,
    output logic                     ser_ready,
    output logic                     ser_shift_req,
    output logic                     modem_irq_line,
    output logic                     modem_out_pin,
    output logic                     modem_out_oe
);
    import mso_pkg::*;

    mso_core_s s;          // registered state
    mso_core_s next_s;     // next state
    logic      wr_ctrl;    // write to control register
    logic      wr_data;    // write to data register
    logic      run;        // output start set
    logic      period_end; // both counters at match
    logic      move;       // write stage to shift stage
    logic      buf_valid;  // buffered serial bit present
    logic      buf_data;   // buffered serial bit
    logic      buf_ready;  // write stage can take a serial bit
    mso_ctrl_s wctrl;      // control value being written

    // ==================================================================
    // serial input buffer
    // ==================================================================
    mso_buf2 u_buf (
        .clock     (clock),
        .rstn      (rstn),
        .in_valid  (ser_valid),
        .in_data   (ser_data),
        .in_ready  (ser_ready),
        .out_valid (buf_valid),
        .out_data  (buf_data),
        .out_ready (buf_ready)
    );

    // ==================================================================
    // decode and timing terms
    // ==================================================================
    assign wr_ctrl = io_req.wr && (io_req.addr == MSO_CTRL_ADDR);
    assign wr_data = io_req.wr && (io_req.addr == MSO_DATA_ADDR);
    assign wctrl   = mso_ctrl_s'(io_req.wdata & MSO_CTRL_WMASK);
    assign run     = s.ctrl.start;
    // period ends when inner and outer counters both match
    assign period_end = (s.phase == MSO_SEND)
                     && (s.baud_cnt == MSO_BAUD_MATCH)
                     && (s.cyc_cnt == MSO_CYCLE_MATCH);
    // pending bit moves at start or at period end, no gap
    assign move = run && s.write_full
               && ((s.phase == MSO_IDLE) || period_end);
    // serial bits load in serial mode while started, once the write stage frees up
    assign buf_ready = run && s.ctrl.serial_data_use
                    && (!s.write_full || move);

    // ==================================================================
    // outputs
    // ==================================================================
    // level request while enabled and no bit pending
    assign modem_irq_line = s.ctrl.empty_irq_enable && !s.write_full;
    assign modem_out_pin  = s.pin.level;
    assign modem_out_oe   = s.pin.oe;
    assign ser_shift_req  = s.shift_req;
    assign io_rdata       = s.rdata;

    // ==================================================================
    // next state
    // ==================================================================
    always_comb begin
        next_s           = s;
        next_s.shift_req = 1'b0;

        // control write, bit 7 kept zero
        if (wr_ctrl) begin
            next_s.ctrl = wctrl;
            // first bit request when serial output starts
            if (wctrl.start && !s.ctrl.start && wctrl.serial_data_use) begin
                next_s.shift_req = 1'b1;
            end
        end

        // nested counters during a bit period
        if (s.phase == MSO_SEND) begin
            if (s.baud_cnt == MSO_BAUD_MATCH) begin
                next_s.baud_cnt = 8'h00;
                if (s.cyc_cnt == MSO_CYCLE_MATCH) begin
                    next_s.cyc_cnt = 8'h00;
                end else begin
                    next_s.cyc_cnt = s.cyc_cnt + 8'h01;
                end
            end else begin
                next_s.baud_cnt = s.baud_cnt + 8'h01;
            end
        end

        case (s.phase)
            MSO_IDLE: begin
                // not sending: counters cleared to zero, pin as left
                next_s.baud_cnt = 8'h00;
                next_s.cyc_cnt  = 8'h00;
            end
            MSO_SEND: begin
                // stop on idle period end or start cleared
                if ((period_end && !move) || !run) begin
                    next_s.phase  = MSO_IDLE;
                    next_s.pin.oe = s.ctrl.hold_level_enable;
                end
            end
            default: begin
                next_s.phase = MSO_IDLE;
            end
        endcase

        // shift move sets the empty flag
        if (move) begin
            next_s.shift_stage = s.write_stage;
            next_s.write_full  = 1'b0;
            next_s.phase       = MSO_SEND;
            next_s.baud_cnt    = 8'h00;
            next_s.cyc_cnt     = 8'h00;
            next_s.pin.level   = s.write_stage;
            next_s.pin.oe      = 1'b1;
            next_s.shift_req   = s.ctrl.serial_data_use;
        end

        // software write lands last, so it clears the flag
        if (wr_data && !s.ctrl.serial_data_use) begin
            // only the lsb is kept for sending
            next_s.write_stage = io_req.wdata[MSO_WBIT];
            next_s.write_full  = 1'b1;
        end else if (buf_valid && buf_ready) begin
            next_s.write_stage = buf_data;
            next_s.write_full  = 1'b1;
        end

        // read data, captured on the strobe
        if (io_req.rd) begin
            if (io_req.addr == MSO_CTRL_ADDR) begin
                next_s.rdata = s.ctrl;
            end else if (io_req.addr == MSO_DATA_ADDR) begin
                next_s.rdata                = 8'h00;
                next_s.rdata[MSO_EMPTY_BIT] = !s.write_full;
                next_s.rdata[MSO_WBIT]      = s.write_stage;
            end else begin
                next_s.rdata = 8'h00;
            end
        end
    end

    // state register
    always_ff @(posedge clock) begin
        if (!rstn) begin
            s <= MSO_CORE_RESET;
        end else begin
            s <= next_s;
        end
    end

    // ==================================================================
    // checks
    // ==================================================================
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    sequence s_launch;
        move && run;
    endsequence

    sequence s_idle_end;
        period_end && !s.write_full;
    endsequence

    property p_irq_on_enable;
        wr_ctrl && io_req.wdata[MSO_IRQEN_BIT] && !s.write_full
            && !(buf_valid && buf_ready)
            |=> modem_irq_line;
    endproperty
    a_irq_on_enable: assert property (p_irq_on_enable)
        else $error("irq not raised with empty flag and enable");

    property p_write_clears;
        wr_data && !s.ctrl.serial_data_use |=> !modem_irq_line
            && s.write_full;
    endproperty
    a_write_clears: assert property (p_write_clears)
        else $error("data write did not clear empty flag");

    property p_lsb_only;
        wr_data && !s.ctrl.serial_data_use
            |=> s.write_stage == $past(io_req.wdata[0]);
    endproperty
    a_lsb_only: assert property (p_lsb_only)
        else $error("write stage did not take written lsb");

    property p_launch;
        (s_launch and (!wr_data && !(buf_valid && buf_ready)))
            |=> !s.write_full && modem_out_oe
            && modem_out_pin == $past(s.write_stage);
    endproperty
    a_launch: assert property (p_launch)
        else $error("bit move did not drive pin and set flag");

    property p_period;
        s_launch |=> (!period_end)[*7] ##1 (period_end || !run);
    endproperty
    a_period: assert property (p_period)
        else $error("bit period length wrong");

    property p_gapless;
        period_end && s.write_full && run
            |=> s.phase == MSO_SEND && s.shift_stage == $past(s.write_stage);
    endproperty
    a_gapless: assert property (p_gapless)
        else $error("pending bit did not follow at period end");

    property p_release;
        (s_idle_end and !s.ctrl.hold_level_enable) |=> !modem_out_oe
            && s.phase == MSO_IDLE;
    endproperty
    a_release: assert property (p_release)
        else $error("pin not released at idle end");

    property p_hold;
        (s_idle_end and s.ctrl.hold_level_enable) |=> modem_out_oe
            && $stable(modem_out_pin) ##1 $stable(modem_out_pin);
    endproperty
    a_hold: assert property (p_hold)
        else $error("pin level not held at idle end");

    property p_stop;
        s.phase == MSO_SEND && !run |=> s.phase == MSO_IDLE;
    endproperty
    a_stop: assert property (p_stop)
        else $error("output did not stop when start cleared");

    property p_read_fields;
        io_req.rd && io_req.addr == MSO_DATA_ADDR
            |=> io_rdata[7] == !$past(s.write_full)
            && io_rdata[6:1] == 6'h00;
    endproperty
    a_read_fields: assert property (p_read_fields)
        else $error("data register read fields wrong");

    property p_ctrl_fields;
        // write, one cycle with no control write, then the read of the control register
        wr_ctrl ##1 !wr_ctrl
            ##1 (io_req.rd && io_req.addr == MSO_CTRL_ADDR && !wr_ctrl)
            |=> io_rdata[6] == $past(io_req.wdata[6], 3)
            && io_rdata[0] == $past(io_req.wdata[0], 3) && !io_rdata[7];
    endproperty
    a_ctrl_fields: assert property (p_ctrl_fields)
        else $error("control readback wrong");

endmodule

// file: rtl/mso_pkg.sv
// Purpose: shared constants and types for the modem bit-serial output block
// Assumes: one system clock, synchronous active-low reset, 8-bit cpu i/o map
// Notes:   state structs and their reset values live here for both modules
//
// How it works
// - empty flag with irq enable drives irq level
// - serial mode: host ends transfer, no indication
// - control bit 6 irq enable, bit 0 start
// - data bit 7 empty flag, bit 0 input
// - only written lsb becomes the next bit
// - shift move sets flag, data write clears
// - pending bit follows without gap when enabled
// - idle end: pin released or level held
package mso_pkg;

    // ==================================================================
    // register map
    // ==================================================================
    localparam logic [7:0] MSO_CTRL_ADDR  = 8'h2a; // modem_output_control
    localparam logic [7:0] MSO_DATA_ADDR  = 8'h2b; // modem_output_data
    localparam logic [7:0] MSO_CTRL_RESET = 8'h00; // control after reset
    localparam logic [7:0] MSO_CTRL_WMASK = 8'h7f; // bit 7 reads zero
    localparam int         MSO_IRQEN_BIT  = 6;     // empty_irq_enable
    localparam int         MSO_START_BIT  = 0;     // output start
    localparam int         MSO_EMPTY_BIT  = 7;     // data_empty_flag
    localparam int         MSO_WBIT       = 0;     // bit_write_stage

    // ==================================================================
    // bit period timing
    // ==================================================================
    localparam logic [7:0] MSO_BAUD_MATCH  = 8'h03; // baud counter top
    localparam logic [7:0] MSO_CYCLE_MATCH = 8'h01; // cycle counter top

    // ==================================================================
    // carriers
    // ==================================================================
    // control register layout, msb first
    typedef struct packed {
        logic       reserved;          // bit 7, reads zero
        logic       empty_irq_enable;  // bit 6
        logic       serial_data_use;   // bit 5
        logic       hold_level_enable; // bit 4
        logic [2:0] rate_sel;          // bits 3..1, stored only
        logic       start;             // bit 0
    } mso_ctrl_s;

    // cpu i/o request
    typedef struct packed {
        logic [7:0] addr;  // i/o address
        logic       wr;    // write strobe, one cycle
        logic       rd;    // read strobe, one cycle
        logic [7:0] wdata; // write data
    } mso_io_req_s;

    // output pin as level plus enable
    typedef struct packed {
        logic level; // driven level
        logic oe;    // high while driving
    } mso_pin_s;

    typedef enum logic { MSO_IDLE, MSO_SEND } mso_phase_e;

    // core state
    typedef struct packed {
        mso_ctrl_s  ctrl;        // control register
        logic       write_stage; // bit_write_stage
        logic       write_full;  // untransferred bit present
        logic       shift_stage; // bit_shift_stage
        mso_phase_e phase;       // sending or idle
        logic [7:0] baud_cnt;    // inner counter
        logic [7:0] cyc_cnt;     // outer counter
        mso_pin_s   pin;         // modem_out_pin drive
        logic       shift_req;   // next-bit request to serial unit
        logic [7:0] rdata;       // read data
    } mso_core_s;

    localparam mso_core_s MSO_CORE_RESET = '0;

    // two-entry buffer state
    typedef struct packed {
        logic [1:0] mem;   // entries
        logic       rd_ptr; // oldest entry
        logic       wr_ptr; // next free entry
        logic [1:0] count;  // 0..2
    } mso_buf_s;

    localparam mso_buf_s   MSO_BUF_RESET = '0;
    localparam logic [1:0] MSO_BUF_DEPTH = 2'h2;

endpackage

// file: rtl/mso_buf2.sv
// Purpose: two-entry bit buffer with valid/ready on both sides
// Assumes: same clock on both sides
// Notes:   in_ready drops only when both entries are held
module mso_buf2 (
    input  wire logic clock,
    input  wire logic rstn,
    input  wire logic in_valid,
    input  wire logic in_data,
    output logic      in_ready,
    output logic      out_valid,
    output logic      out_data,
    input  wire logic out_ready
);
    import mso_pkg::*;

    mso_buf_s s;      // registered state
    mso_buf_s next_s; // next state
    logic     push;   // entry taken
    logic     pop;    // entry given

    // ==================================================================
    // handshakes
    // ==================================================================
    assign in_ready  = (s.count != MSO_BUF_DEPTH);
    assign out_valid = (s.count != 2'h0);
    assign out_data  = s.mem[s.rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // next state
    always_comb begin
        next_s = s;
        if (push) begin
            next_s.mem[s.wr_ptr] = in_data;
            next_s.wr_ptr        = ~s.wr_ptr;
        end
        if (pop) begin
            next_s.rd_ptr = ~s.rd_ptr;
        end
        // count moves only when one side acts alone
        if (push && !pop) begin
            next_s.count = s.count + 2'h1;
        end else if (pop && !push) begin
            next_s.count = s.count - 2'h1;
        end
    end

    // state register
    always_ff @(posedge clock) begin
        if (!rstn) begin
            s <= MSO_BUF_RESET;
        end else begin
            s <= next_s;
        end
    end

endmodule

// file: dv/mso_ser_model.sv
// Purpose: serial buffer unit model feeding bits to the modem output
// Assumes: bits loaded msb first, handed over on valid and ready
// Notes:   paced mode offers one bit per shift request seen
module mso_ser_model (
    input  wire logic       clock,
    input  wire logic       rstn,
    input  wire logic       paced,
    input  wire logic       load,
    input  wire logic [7:0] load_bits,
    input  wire logic [3:0] load_cnt,
    input  wire logic       ser_ready,
    input  wire logic       ser_shift_req,
    output logic            ser_valid,
    output logic            ser_data,
    output logic            done
);
    logic [7:0] bits;          // bits left, msb goes next
    logic [3:0] left;          // number of bits left
    logic [3:0] credit;        // shift requests not yet answered
    logic       last = 1'h0;   // last bit handed over
    logic       take;          // bit accepted at this edge
    // offer stands until taken; a released line shows the inverse level
    assign take      = ser_valid & ser_ready;
    assign ser_valid = (left != 4'h0) && (!paced || credit != 4'h0);
    assign ser_data  = ser_valid ? bits[7] : ~last;
    assign done      = (left == 4'h0);
    // state moves only on the rising edge
    always @(posedge clock) begin
        if (!rstn) begin
            left   <= 4'h0;
            credit <= 4'h0;
        end else if (load) begin
            bits   <= load_bits;
            left   <= load_cnt;
            credit <= 4'h0;
        end else begin
            credit <= paced ? credit + 4'(ser_shift_req) - 4'(take) : 4'h0;
            if (take) begin
                bits <= {bits[6:0], 1'h0};
                left <= left - 4'h1;
                last <= bits[7];
            end
        end
    end
endmodule

// file: dv/mso_modem_out_test.sv
// Purpose: self-checking bench for the modem bit-serial output
// Assumes: inputs driven on the falling edge, outputs logged on rising
// Notes:   one bit period is 8 cycles with the package match values
module mso_modem_out_test;
    timeunit 1ns;
    timeprecision 1ps;
    import mso_pkg::*;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdat;
        logic       irq;
    } mso_row_s;
    // register rows: write, read back, irq level after
    localparam mso_row_s ROWS[6] = '{
        '{8'h2a, 8'hfe, 8'h7e, 1'h1}, '{8'h2b, 8'h01, 8'h80, 1'h1},
        '{8'h2a, 8'h40, 8'h40, 1'h1}, '{8'h2b, 8'hfe, 8'h00, 1'h0},
        '{8'h2b, 8'h03, 8'h01, 1'h0}, '{8'h2a, 8'h00, 8'h00, 1'h0}};
    logic        clock = 1'h0;   // system clock
    logic        rstn  = 1'h0;   // reset, active low
    mso_io_req_s io_req = '0;    // cpu request
    logic [7:0]  io_rdata;
    logic        ser_valid;
    logic        ser_data;
    logic        ser_ready;
    logic        ser_shift_req;
    logic        irq;
    logic        pin;
    logic        oe;
    logic        paced = 1'h0;
    logic        load  = 1'h0;
    logic        done;
    logic [7:0]  load_bits = 8'h00;
    logic [3:0]  load_cnt  = 4'h0;
    logic [7:0]  seq;            // pin level at the first four period starts
    logic        saw_full;       // buffer refused a bit
    logic [7:0]  rd;
    int          error_cnt = 0;
    int          n_tests   = 0;
    int          cycles    = 0;
    int          hi_cnt;
    int          lo_cnt;
    int          per       = 0;
    int          npush;
    always #5 clock = ~clock;
    mso_modem_out i_mso_modem_out (
        .clock          (clock),
        .rstn           (rstn),
        .io_req         (io_req),
        .io_rdata       (io_rdata),
        .ser_valid      (ser_valid),
        .ser_data       (ser_data),
        .ser_ready      (ser_ready),
        .ser_shift_req  (ser_shift_req),
        .modem_irq_line (irq),
        .modem_out_pin  (pin),
        .modem_out_oe   (oe)
    );
    mso_ser_model i_mso_ser_model (
        .clock         (clock),
        .rstn          (rstn),
        .paced         (paced),
        .load          (load),
        .load_bits     (load_bits),
        .load_cnt      (load_cnt),
        .ser_ready     (ser_ready),
        .ser_shift_req (ser_shift_req),
        .ser_valid     (ser_valid),
        .ser_data      (ser_data),
        .done          (done)
    );
    // ==================================================================
    // pin log and timeout, sampled on the rising edge
    // ==================================================================
    always @(posedge clock) begin
        cycles++;
        if (!ser_ready)
            saw_full = 1'h1;
        if (oe === 1'h1) begin
            if (per == 0 && npush < 4) begin
                seq = {seq[6:0], pin};
                npush++;
            end
            if (pin)
                hi_cnt++;
            else
                lo_cnt++;
            per = (per == 7) ? 0 : per + 1;
        end else
            per = 0;
        if (cycles == 20000) begin
            error_cnt++;
            stop_test();
        end
    end
    // ==================================================================
    // tasks
    // ==================================================================
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic io_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        io_req = '{addr: a, wr: 1'h1, rd: 1'h0, wdata: d};
        @(negedge clock);
        io_req.wr = 1'h0;
    endtask
    task automatic io_rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        io_req = '{addr: a, wr: 1'h0, rd: 1'h1, wdata: 8'h00};
        @(negedge clock);
        io_req.rd = 1'h0;
        d = io_rdata;
    endtask
    task automatic clr();
        hi_cnt = 0;
        lo_cnt = 0;
        npush = 0;
        seq = 8'h00;
        saw_full = 1'h0;
    endtask
    task automatic wait_oe(input logic lvl);
        int k;
        k = 0;
        while (oe !== lvl && k < 80) begin
            @(negedge clock);
            k++;
        end
        check("modem_out_oe", {7'h00, oe}, {7'h00, lvl});
    endtask
    task automatic chk_idle();
        check("modem_out_oe", {7'h00, oe}, 8'h00);
        check("modem_irq_line", {7'h00, irq}, 8'h00);
        io_rd(MSO_CTRL_ADDR, rd);
        check("control", rd, MSO_CTRL_RESET);
        io_rd(MSO_DATA_ADDR, rd);
        check("data", rd, 8'h80);
        io_rd(8'h2c, rd);
        check("unmapped", rd, 8'h00);
    endtask
    task automatic stop_test();
        if (error_cnt == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ==================================================================
    // main sequence
    // ==================================================================
    initial begin
        clr();
        repeat (8) @(negedge clock);
        rstn = 1'h1;
        chk_idle();
        foreach (ROWS[i]) begin
            io_wr(ROWS[i].addr, ROWS[i].wdata);
            io_rd(ROWS[i].addr, rd);
            check("register", rd, ROWS[i].rdat);
            check("irq", {7'h00, irq}, {7'h00, ROWS[i].irq});
        end
        // two written bits back to back, pin released at the end
        clr();
        io_wr(MSO_CTRL_ADDR, 8'h40);
        io_wr(MSO_CTRL_ADDR, 8'h41);
        wait_oe(1'h1);
        check("modem_out_pin", {7'h00, pin}, 8'h01);
        check("irq on move", {7'h00, irq}, 8'h01);
        io_wr(MSO_DATA_ADDR, 8'hfe);
        check("irq on write", {7'h00, irq}, 8'h00);
        wait_oe(1'h0);
        check("high cycles", 8'(hi_cnt), 8'h08);
        check("low cycles", 8'(lo_cnt), 8'h08);
        check("bit order", seq, 8'h02);
        check("irq when empty", {7'h00, irq}, 8'h01);
        io_wr(MSO_CTRL_ADDR, 8'h00);
        // last level held, then a reset in mid-run
        io_wr(MSO_DATA_ADDR, 8'h01);
        io_wr(MSO_CTRL_ADDR, 8'h10);
        io_wr(MSO_CTRL_ADDR, 8'h11);
        wait_oe(1'h1);
        repeat (24) @(negedge clock);
        check("held oe", {7'h00, oe}, 8'h01);
        check("held pin", {7'h00, pin}, 8'h01);
        rstn = 1'h0;
        repeat (2) @(negedge clock);
        rstn = 1'h1;
        chk_idle();
        // serial unit bits, prompt then paced
        for (int p = 0; p < 2; p++) begin
            paced = p[0];
            clr();
            load_bits = 8'h90;
            load_cnt = 4'h4;
            load = 1'h1;
            @(negedge clock);
            load = 1'h0;
            io_wr(MSO_CTRL_ADDR, 8'h20);
            io_wr(MSO_CTRL_ADDR, 8'h21);
            for (int k = 0; k < 100 && npush < 4; k++)
                @(negedge clock);
            repeat (8) @(negedge clock);
            check("done", {7'h00, done}, 8'h01);
            io_wr(MSO_CTRL_ADDR, 8'h00);
            wait_oe(1'h0);
            check("serial bits", seq, 8'h09);
            check("full", {7'h00, saw_full}, {7'h00, ~paced});
            check("ser_ready", {7'h00, ser_ready}, 8'h01);
        end
        stop_test();
    end
endmodule
